//--- rtl/srbs_defines.svh
// Offsets, field positions, mode codes and timing counts of the reset and strap block
`ifndef SRBS_DEFINES_SVH
`define SRBS_DEFINES_SVH
`define SRBS_ADDR_W        8
`define SRBS_DATA_W        32
`define SRBS_GPIO_N        3
`define SRBS_SYNC_W        12
`define SRBS_OFS_SWCTL     8'h00
`define SRBS_OFS_STRAP     8'h04
`define SRBS_OFS_MODE      8'h08
`define SRBS_OFS_GPIO_OUT  8'h0c
`define SRBS_OFS_GPIO_DIR  8'h10
`define SRBS_OFS_GPIO_IN   8'h14
`define SRBS_OFS_GPIO_ALT  8'h18
`define SRBS_SWCTL_HOLD    0
`define SRBS_MODE_EEPROM   0
`define SRBS_MODE_FAILOVER 1
`define SRBS_MODE_RSVD     2
`define SRBS_MODE_PORT_LSB 4
`define SRBS_MODE_ST_LSB   8
`define SRBS_ALT_IRQ_PIN   2
`define SRBS_RESP_OKAY     2'h0
`define SRBS_RESP_SLVERR   2'h2
`define SRBS_SM_NORMAL     4'h0
`define SRBS_SM_EEPROM     4'h1
`define SRBS_SM_FO_P0      4'h8
`define SRBS_SM_EE_FO_P0   4'h9
`define SRBS_SM_EE_FO_A    4'ha
`define SRBS_SM_EE_FO_P2   4'hb
`define SRBS_SM_RSVD_LO    4'h2
`define SRBS_SM_RSVD_HI    4'h7
`define SRBS_PORT_ZERO     4'h0
`define SRBS_PORT_TWO      4'h2
`define SRBS_CLK_KHZ       100000
`define SRBS_SMB_SLOW_KHZ  100
`define SRBS_SMB_FAST_KHZ  400
`define SRBS_SMB_SLOW_CYC  (`SRBS_CLK_KHZ / `SRBS_SMB_SLOW_KHZ)
`define SRBS_SMB_FAST_CYC  (`SRBS_CLK_KHZ / `SRBS_SMB_FAST_KHZ)
`define SRBS_SMB_CNT_W     10
`define SRBS_RESET_PROC_CYC 16
`define SRBS_PROC_CNT_W    5
`endif

//--- rtl/srbs_pkg.sv
// Types shared by the reset and strap block
package srbs_pkg;
`include "srbs_defines.svh"
  typedef struct packed {
    logic                     awvalid;
    logic [`SRBS_ADDR_W-1:0]  awaddr;
    logic                     wvalid;
    logic [`SRBS_DATA_W-1:0]  wdata;
    logic [3:0]               wstrb;
    logic                     bready;
    logic                     arvalid;
    logic [`SRBS_ADDR_W-1:0]  araddr;
    logic                     rready;
  } srbs_axi_req_type;
  typedef struct packed {
    logic                     awready;
    logic                     wready;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     arready;
    logic                     rvalid;
    logic [`SRBS_DATA_W-1:0]  rdata;
    logic [1:0]               rresp;
  } srbs_axi_rsp_type;
  typedef struct packed {
    logic       ds_common_clock;
    logic       us_common_clock;
    logic       smbus_slow;
    logic       hold_request;
    logic [3:0] operating_mode;
  } srbs_strap_type;
  typedef enum logic [2:0] {
    SRBS_ST_FUND_RESET = 3'b000,
    SRBS_ST_RESET_PROC = 3'b001,
    SRBS_ST_EEPROM     = 3'b010,
    SRBS_ST_HALTED     = 3'b011,
    SRBS_ST_RUN        = 3'b100
  } srbs_state_type;
endpackage

//--- rtl/srbs_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module srbs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end
  assign sync_out = sync_ff;
endmodule

//--- rtl/srbs_top.sv
// Reset sequencing, boot straps, mode decode and three GPIO pins behind AXI4-Lite
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "srbs_defines.svh"
// How it works
// (RULE1) Latched downstream common-clock strap drives the downstream shared-clock output.
// (RULE2) Latched upstream common-clock strap drives the upstream shared-clock output.
// (RULE3) Slow strap gives a 100 kHz master SMBus bit tick, else 400 kHz.
// (RULE4) SMBus speed comes from the strap only; no register can change it.
// (RULE5) Low fundamental reset resets internal logic and holds PCIe fundamental reset.
// (RULE6) Hold strap: finish reset procedure, then stay halted with both SMBuses enabled.
// (RULE7) Registers stay readable and writable while the device is halted.
// (RULE8) Clearing the hold bit in switch control releases the halt into operation.
// (RULE9) Board keeps mode straps static once fundamental reset is released.
// (RULE10) Mode 0x0 is normal; mode 0x1 adds EEPROM loading first.
// (RULE11) Modes 0x2 to 0x7 are reserved and select no defined mode.
// (RULE12) Mode 0x8 is normal with upstream failover, upstream port 0.
// (RULE13) Mode 0x9 adds EEPROM loading to failover with upstream port 0.
// (RULE14) Modes 0xA and 0xB: EEPROM plus failover, ports 0 and 2.
// (RULE15) Pins 29 to 31 are GPIO; pin 31 may be expander interrupt ten.
// (RULE16) Straps are sampled during fundamental reset and kept from its release.
module srbs_top (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           fundamental_reset_n,
  input  wire srbs_pkg::srbs_strap_type       strap_pins,
  input  wire logic                           eeprom_load_done,
  input  wire logic [`SRBS_GPIO_N-1:0]        gpio_in,
  output logic      [`SRBS_GPIO_N-1:0]        gpio_out,
  output logic      [`SRBS_GPIO_N-1:0]        gpio_oe,
  input  wire srbs_pkg::srbs_axi_req_type     axi_req,
  output srbs_pkg::srbs_axi_rsp_type          axi_rsp,
  output logic                                core_reset_n,
  output logic                                pcie_fund_reset,
  output logic                                smbus_enable,
  output logic                                eeprom_load_req,
  output logic                                failover_enable,
  output logic      [3:0]                     upstream_port,
  output logic                                ds_common_clock,
  output logic                                us_common_clock,
  output logic                                master_smbus_tick,
  output logic                                io_expander_irq_ten
);
  import srbs_pkg::*;

  logic [`SRBS_SYNC_W-1:0] sync_q;
  srbs_sync #(.WIDTH(`SRBS_SYNC_W)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({gpio_in, strap_pins, fundamental_reset_n}),
    .sync_out (sync_q)
  );
  wire                     fund_n_s  = sync_q[0];
  wire srbs_strap_type     strap_s   = sync_q[8:1];
  wire [`SRBS_GPIO_N-1:0]  gpio_s    = sync_q[`SRBS_SYNC_W-1:9];

  srbs_state_type              state_ff;
  srbs_state_type              nxt_state;
  srbs_strap_type              strap_ff;
  logic [`SRBS_PROC_CNT_W-1:0] proc_cnt_ff;
  logic                        hold_ff;
  logic [`SRBS_SMB_CNT_W-1:0]  smb_cnt_ff;
  logic                        smb_tick_ff;
  logic                        core_rst_n_ff;
  logic                        pcie_rst_ff;
  logic                        smb_en_ff;
  logic                        ee_req_ff;
  logic                        fo_ff;
  logic [3:0]                  port_ff;
  logic                        ds_ff;
  logic                        us_ff;
  logic                        irq_ff;
  logic [`SRBS_GPIO_N-1:0]     gpio_out_ff;
  logic [`SRBS_GPIO_N-1:0]     gpio_dir_ff;
  logic [`SRBS_GPIO_N-1:0]     gpio_oe_ff;
  logic [`SRBS_GPIO_N-1:0]     gpio_pin_ff;
  logic                        alt_ff;

  // Mode decode of the latched straps
  wire [3:0] mode       = strap_ff.operating_mode;
  wire mode_ee          = (mode == `SRBS_SM_EEPROM) | // [RULE10]
                          (mode == `SRBS_SM_EE_FO_P0) | // [RULE13]
                          (mode == `SRBS_SM_EE_FO_A) | (mode == `SRBS_SM_EE_FO_P2); // [RULE14]
  wire mode_fo          = (mode == `SRBS_SM_FO_P0) | // [RULE12]
                          (mode == `SRBS_SM_EE_FO_P0) | // [RULE13]
                          (mode == `SRBS_SM_EE_FO_A) | (mode == `SRBS_SM_EE_FO_P2); // [RULE14]
  wire mode_rsvd        = ~mode_fo & (mode != `SRBS_SM_NORMAL) & ~mode_ee; // [RULE11]
  wire [3:0] mode_port  = (mode == `SRBS_SM_EE_FO_P2) ? `SRBS_PORT_TWO : `SRBS_PORT_ZERO;

  wire proc_done = (proc_cnt_ff == `SRBS_PROC_CNT_W'(`SRBS_RESET_PROC_CYC - 1));
  wire hold_clr;

  // Sequencer; reserved modes run with no EEPROM load and no failover
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SRBS_ST_FUND_RESET: nxt_state = SRBS_ST_RESET_PROC;
      SRBS_ST_RESET_PROC: begin
        if (proc_done) begin // [RULE6]
          nxt_state = hold_ff ? SRBS_ST_HALTED : (mode_ee ? SRBS_ST_EEPROM : SRBS_ST_RUN);
        end
      end
      SRBS_ST_HALTED: begin
        if (!hold_ff) begin
          nxt_state = mode_ee ? SRBS_ST_EEPROM : SRBS_ST_RUN; // [RULE8]
        end
      end
      SRBS_ST_EEPROM: begin
        if (eeprom_load_done) begin
          nxt_state = SRBS_ST_RUN; // [RULE10]
        end
      end
      SRBS_ST_RUN: nxt_state = SRBS_ST_RUN;
      default: nxt_state = SRBS_ST_FUND_RESET;
    endcase
    if (!fund_n_s) begin
      nxt_state = SRBS_ST_FUND_RESET; // [RULE5]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff    <= SRBS_ST_FUND_RESET;
      proc_cnt_ff <= '0;
    end else begin
      state_ff    <= nxt_state;
      proc_cnt_ff <= (state_ff == SRBS_ST_RESET_PROC) ? proc_cnt_ff + 1'b1 : '0;
    end
  end

  // Straps follow the pins only while fundamental reset is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_ff <= '0;
    end else if (state_ff == SRBS_ST_FUND_RESET) begin
      strap_ff <= strap_s; // [RULE16] [RULE9]
    end
  end

  // Hold bit: strap sets it in reset, software only clears; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_ff <= 1'b0;
    end else if (state_ff == SRBS_ST_FUND_RESET) begin
      hold_ff <= strap_s.hold_request; // [RULE6]
    end else if (hold_clr) begin
      hold_ff <= 1'b0; // [RULE8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_rst_n_ff <= 1'b0;
      pcie_rst_ff   <= 1'b1;
      smb_en_ff     <= 1'b0;
      ee_req_ff     <= 1'b0;
      fo_ff         <= 1'b0;
      port_ff       <= '0;
      ds_ff         <= 1'b0;
      us_ff         <= 1'b0;
    end else begin
      core_rst_n_ff <= (nxt_state == SRBS_ST_RUN); // [RULE5]
      pcie_rst_ff   <= (nxt_state == SRBS_ST_FUND_RESET) | (nxt_state == SRBS_ST_RESET_PROC);
      smb_en_ff     <= (nxt_state == SRBS_ST_HALTED) | (nxt_state == SRBS_ST_EEPROM) |
                       (nxt_state == SRBS_ST_RUN); // [RULE6]
      ee_req_ff     <= (nxt_state == SRBS_ST_EEPROM); // [RULE10]
      fo_ff         <= mode_fo & ~mode_rsvd; // [RULE12]
      port_ff       <= mode_port; // [RULE12] [RULE14]
      ds_ff         <= strap_ff.ds_common_clock; // [RULE1]
      us_ff         <= strap_ff.us_common_clock; // [RULE2]
    end
  end

  // Bit tick of the master SMBus; rate fixed by the strap alone
  wire [`SRBS_SMB_CNT_W-1:0] smb_last = strap_ff.smbus_slow ? // [RULE3] [RULE4]
                                        `SRBS_SMB_CNT_W'(`SRBS_SMB_SLOW_CYC - 1) :
                                        `SRBS_SMB_CNT_W'(`SRBS_SMB_FAST_CYC - 1);
  wire smb_wrap = (smb_cnt_ff >= smb_last);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smb_cnt_ff  <= '0;
      smb_tick_ff <= 1'b0;
    end else if (!smb_en_ff) begin
      smb_cnt_ff  <= '0;
      smb_tick_ff <= 1'b0;
    end else begin
      smb_cnt_ff  <= smb_wrap ? '0 : smb_cnt_ff + 1'b1; // [RULE3]
      smb_tick_ff <= smb_wrap;
    end
  end

  // GPIO pins; pin 31 as interrupt input stops driving one cycle after alt_ff sets
  genvar gi;
  generate
    for (gi = 0; gi < `SRBS_GPIO_N; gi++) begin : g_gpio
      wire alt_here = (gi == `SRBS_ALT_IRQ_PIN) & alt_ff;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          gpio_oe_ff[gi]  <= 1'b0;
          gpio_pin_ff[gi] <= 1'b0;
        end else begin
          gpio_oe_ff[gi]  <= gpio_dir_ff[gi] & ~alt_here; // [RULE15]
          gpio_pin_ff[gi] <= gpio_s[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= alt_ff & ~gpio_s[`SRBS_ALT_IRQ_PIN]; // [RULE15]
    end
  end

  // AXI4-Lite slave, usable in every state including the halt
  logic                     aw_held_ff;
  logic                     w_held_ff;
  logic                     aw_rdy_ff;
  logic                     w_rdy_ff;
  logic [`SRBS_ADDR_W-1:0]  aw_addr_ff;
  logic [`SRBS_DATA_W-1:0]  w_data_ff;
  logic                     w_lane0_ff;
  logic                     bvalid_ff;
  logic [1:0]               bresp_ff;
  logic                     ar_rdy_ff;
  logic                     rvalid_ff;
  logic [`SRBS_DATA_W-1:0]  rdata_ff;
  logic [1:0]               rresp_ff;

  wire aw_take      = axi_req.awvalid & aw_rdy_ff;
  wire w_take       = axi_req.wvalid & w_rdy_ff;
  wire do_write     = aw_held_ff & w_held_ff & ~bvalid_ff; // [RULE7]
  wire nxt_aw_held  = (aw_held_ff & ~do_write) | aw_take;
  wire nxt_w_held   = (w_held_ff & ~do_write) | w_take;
  wire nxt_bvalid   = do_write | (bvalid_ff & ~axi_req.bready);
  wire ar_take      = axi_req.arvalid & ar_rdy_ff;
  wire nxt_rvalid   = ar_take | (rvalid_ff & ~axi_req.rready);
  wire wr_lane      = do_write & w_lane0_ff;
  wire wr_swctl     = (aw_addr_ff == `SRBS_OFS_SWCTL);
  wire wr_gout      = (aw_addr_ff == `SRBS_OFS_GPIO_OUT);
  wire wr_gdir      = (aw_addr_ff == `SRBS_OFS_GPIO_DIR);
  wire wr_galt      = (aw_addr_ff == `SRBS_OFS_GPIO_ALT);
  wire wr_ro        = (aw_addr_ff == `SRBS_OFS_STRAP) | (aw_addr_ff == `SRBS_OFS_MODE) |
                      (aw_addr_ff == `SRBS_OFS_GPIO_IN); // [RULE4]
  wire wr_hit       = wr_swctl | wr_gout | wr_gdir | wr_galt | wr_ro;
  assign hold_clr   = wr_lane & wr_swctl & ~w_data_ff[`SRBS_SWCTL_HOLD]; // [RULE8]

  wire [`SRBS_ADDR_W-1:0] ra = axi_req.araddr;
  wire [`SRBS_DATA_W-1:0] rd_swctl = `SRBS_DATA_W'(hold_ff) << `SRBS_SWCTL_HOLD;
  wire [`SRBS_DATA_W-1:0] rd_strap = `SRBS_DATA_W'(strap_ff);
  wire [`SRBS_DATA_W-1:0] rd_mode  = (`SRBS_DATA_W'(mode_ee) << `SRBS_MODE_EEPROM) |
                                     (`SRBS_DATA_W'(mode_fo) << `SRBS_MODE_FAILOVER) |
                                     (`SRBS_DATA_W'(mode_rsvd) << `SRBS_MODE_RSVD) |
                                     (`SRBS_DATA_W'(mode_port) << `SRBS_MODE_PORT_LSB) |
                                     (`SRBS_DATA_W'(state_ff) << `SRBS_MODE_ST_LSB);
  wire rd_hit = (ra == `SRBS_OFS_SWCTL) | (ra == `SRBS_OFS_STRAP) | (ra == `SRBS_OFS_MODE) |
                (ra == `SRBS_OFS_GPIO_OUT) | (ra == `SRBS_OFS_GPIO_DIR) |
                (ra == `SRBS_OFS_GPIO_IN) | (ra == `SRBS_OFS_GPIO_ALT);
  wire [`SRBS_DATA_W-1:0] rd_data =
    (ra == `SRBS_OFS_SWCTL)    ? rd_swctl :
    (ra == `SRBS_OFS_STRAP)    ? rd_strap :
    (ra == `SRBS_OFS_MODE)     ? rd_mode :
    (ra == `SRBS_OFS_GPIO_OUT) ? `SRBS_DATA_W'(gpio_out_ff) :
    (ra == `SRBS_OFS_GPIO_DIR) ? `SRBS_DATA_W'(gpio_dir_ff) :
    (ra == `SRBS_OFS_GPIO_IN)  ? `SRBS_DATA_W'(gpio_pin_ff) :
    (ra == `SRBS_OFS_GPIO_ALT) ? `SRBS_DATA_W'(alt_ff) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_rdy_ff  <= 1'b0;
      w_rdy_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      ar_rdy_ff  <= 1'b0;
      rvalid_ff  <= 1'b0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      aw_rdy_ff  <= ~nxt_aw_held;
      w_rdy_ff   <= ~nxt_w_held;
      bvalid_ff  <= nxt_bvalid;
      ar_rdy_ff  <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
    end
  end

  // Payload registers need no reset; valids guard them
  always_ff @(posedge aclk) begin
    if (aw_take) aw_addr_ff <= axi_req.awaddr;
    if (w_take) w_data_ff <= axi_req.wdata;
    if (w_take) w_lane0_ff <= axi_req.wstrb[0];
    if (do_write) bresp_ff <= wr_hit ? `SRBS_RESP_OKAY : `SRBS_RESP_SLVERR;
    if (ar_take) rdata_ff <= rd_data;
    if (ar_take) rresp_ff <= rd_hit ? `SRBS_RESP_OKAY : `SRBS_RESP_SLVERR;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_out_ff <= '0;
      gpio_dir_ff <= '0;
      alt_ff      <= 1'b0;
    end else if (wr_lane) begin
      if (wr_gout) gpio_out_ff <= w_data_ff[`SRBS_GPIO_N-1:0]; // [RULE15]
      if (wr_gdir) gpio_dir_ff <= w_data_ff[`SRBS_GPIO_N-1:0]; // [RULE15]
      if (wr_galt) alt_ff <= w_data_ff[0]; // [RULE15]
    end
  end

  assign axi_rsp = '{awready: aw_rdy_ff, wready: w_rdy_ff, bvalid: bvalid_ff,
                     bresp: bresp_ff, arready: ar_rdy_ff, rvalid: rvalid_ff,
                     rdata: rdata_ff, rresp: rresp_ff};
  assign gpio_out            = gpio_out_ff;
  assign gpio_oe             = gpio_oe_ff;
  assign core_reset_n        = core_rst_n_ff;
  assign pcie_fund_reset     = pcie_rst_ff;
  assign smbus_enable        = smb_en_ff;
  assign eeprom_load_req     = ee_req_ff;
  assign failover_enable     = fo_ff;
  assign upstream_port       = port_ff;
  assign ds_common_clock     = ds_ff;
  assign us_common_clock     = us_ff;
  assign master_smbus_tick   = smb_tick_ff;
  assign io_expander_irq_ten = irq_ff;

  // Checks
  logic [`SRBS_SMB_CNT_W-1:0] gap_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || smb_tick_ff) gap_ff <= '0;
    else if (!smb_en_ff) gap_ff <= '1; // First period after enable is the same length; counting starts one below zero
    else gap_ff <= gap_ff + 1'b1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_halt_entry: assert property ( // [RULE6]
    (state_ff == SRBS_ST_RESET_PROC) && proc_done && hold_ff && fund_n_s
    |=> (state_ff == SRBS_ST_HALTED) ##1 (smb_en_ff && !core_rst_n_ff))
    else $error("halt not entered after reset procedure");
  chk_halt_release: assert property ( // [RULE8]
    (state_ff == SRBS_ST_HALTED) && hold_clr && fund_n_s |=> ##1 smb_en_ff ##0
    (state_ff != SRBS_ST_HALTED))
    else $error("halt not released by clear of hold bit");
  chk_halt_stays: assert property ( // [RULE6]
    (state_ff == SRBS_ST_HALTED) && hold_ff && fund_n_s |=> (state_ff == SRBS_ST_HALTED))
    else $error("halt left while hold bit set");
  chk_fund_reset: assert property ( // [RULE5]
    !fund_n_s |=> (state_ff == SRBS_ST_FUND_RESET) && !core_rst_n_ff && pcie_rst_ff)
    else $error("fundamental reset not applied");
  chk_smbus_period: assert property ( // [RULE3]
    smb_tick_ff && $stable(strap_ff) && (gap_ff != 0) |->
    gap_ff == (strap_ff.smbus_slow ? `SRBS_SMB_CNT_W'(`SRBS_SMB_SLOW_CYC - 1) :
                                     `SRBS_SMB_CNT_W'(`SRBS_SMB_FAST_CYC - 1)))
    else $error("master SMBus tick period wrong");
  chk_speed_locked: assert property ( // [RULE4]
    (state_ff != SRBS_ST_FUND_RESET) |=> $stable(strap_ff.smbus_slow))
    else $error("SMBus speed changed outside reset");
  chk_straps_held: assert property ( // [RULE16]
    (state_ff != SRBS_ST_FUND_RESET) |=> $stable(strap_ff))
    else $error("straps changed outside fundamental reset");
  chk_reserved_mode: assert property ( // [RULE11]
    (mode >= `SRBS_SM_RSVD_LO) && (mode <= `SRBS_SM_RSVD_HI) |-> mode_rsvd && !mode_ee
    ##1 !fo_ff)
    else $error("reserved mode decoded as defined");
  chk_eeprom_path: assert property ( // [RULE10]
    (state_ff == SRBS_ST_RESET_PROC) && proc_done && !hold_ff && fund_n_s |=>
    (state_ff == (mode_ee ? SRBS_ST_EEPROM : SRBS_ST_RUN)))
    else $error("EEPROM load step wrong for mode");
  chk_upstream_port: assert property ( // [RULE12]
    (mode == `SRBS_SM_FO_P0) && (state_ff == SRBS_ST_RUN) && $stable(mode) |->
    fo_ff && (port_ff == `SRBS_PORT_ZERO))
    else $error("failover mode port wrong");
  chk_irq_pin: assert property ( // [RULE15]
    alt_ff && $past(alt_ff) |-> !gpio_oe_ff[`SRBS_ALT_IRQ_PIN])
    else $error("interrupt pin driven");
endmodule

//--- tb/srbs_board_model.sv
// Board reset, strap pins and EEPROM loader facing the reset and strap block
`timescale 1ns/10ps
module srbs_board_model (
  input  wire logic                aclk,
  input  wire logic                eeprom_load_req,
  output logic                     fundamental_reset_n,
  output srbs_pkg::srbs_strap_type strap_pins,
  output logic                     eeprom_load_done
);
  import srbs_pkg::*;
  logic [1:0] wait_ff;
  initial begin
    fundamental_reset_n = 1'b0;
    strap_pins = '0;
    eeprom_load_done = 1'b0;
    wait_ff = 2'h0;
  end
  // Straps move only while reset is low, then stay put
  task automatic boot(input srbs_strap_type s);
    @(posedge aclk);
    fundamental_reset_n <= 1'b0;
    repeat (2) @(posedge aclk);
    strap_pins <= s;
    repeat (4) @(posedge aclk);
    fundamental_reset_n <= 1'b1;
  endtask
  // Load ends a few cycles late, never at once
  always @(posedge aclk) begin
    wait_ff <= eeprom_load_req ? wait_ff + 2'h1 : 2'h0;
    eeprom_load_done <= eeprom_load_req && (wait_ff == 2'h3);
  end
endmodule

//--- tb/srbs_top_tb.sv
// Self-checking bench for the reset and strap block
`timescale 1ns/10ps
`include "srbs_defines.svh"
module srbs_top_tb;
  import srbs_pkg::*;
  logic             aclk = 1'b0;
  logic             aresetn = 1'b0;
  logic             fundamental_reset_n, eeprom_load_done, eeprom_load_req;
  srbs_strap_type   strap_pins, s;
  logic [2:0]       gpio_in = 3'h7;
  logic [2:0]       gpio_out, gpio_oe;
  srbs_axi_req_type req = '0;
  srbs_axi_rsp_type rsp;
  logic             core_reset_n, pcie_fund_reset, smbus_enable, failover_enable;
  logic             ds_common_clock, us_common_clock, master_smbus_tick, io_expander_irq_ten;
  logic [3:0]       upstream_port, m, port;
  logic             ee, fo, rsv;
  logic [31:0]      rd;
  logic [1:0]       rr;
  int               n;
  int               n_fail = 0;
  int               num_checks = 0;
  logic [3:0]       modes [9] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hf};
  always #5 aclk = ~aclk;
  srbs_board_model i_srbs_board_model (.aclk(aclk), .eeprom_load_req(eeprom_load_req),
    .fundamental_reset_n(fundamental_reset_n), .strap_pins(strap_pins),
    .eeprom_load_done(eeprom_load_done));
  srbs_top i_srbs_top (.aclk(aclk), .aresetn(aresetn), .fundamental_reset_n(fundamental_reset_n),
    .strap_pins(strap_pins), .eeprom_load_done(eeprom_load_done), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .axi_req(req), .axi_rsp(rsp),
    .core_reset_n(core_reset_n), .pcie_fund_reset(pcie_fund_reset),
    .smbus_enable(smbus_enable), .eeprom_load_req(eeprom_load_req),
    .failover_enable(failover_enable), .upstream_port(upstream_port),
    .ds_common_clock(ds_common_clock), .us_common_clock(us_common_clock),
    .master_smbus_tick(master_smbus_tick), .io_expander_irq_ten(io_expander_irq_ten));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    {req.awvalid, req.wvalid, req.bready} <= 3'b111;
    while (!done) begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    req.araddr <= a;
    {req.arvalid, req.rready} <= 2'b11;
    while (!done) begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // Cuts a hang short; the full run is a few thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      m = modes[i];
      s = srbs_strap_type'({i[0], i[1], i == 0, i == 2 || i == 5, m});
      ee = (m == 4'h1) || (m >= 4'h9 && m <= 4'hb);
      fo = m >= 4'h8 && m <= 4'hb;
      port = (m == 4'hb) ? 4'h2 : 4'h0;
      rsv = !(m == 4'h0 || ee || fo);
      i_srbs_board_model.boot(s);
      chk("fund_reset", {pcie_fund_reset, core_reset_n}, 2'b10);
      for (n = 0; n < 60 && smbus_enable !== 1'b1; n++) @(posedge aclk);
      if (s.hold_request) begin
        repeat (4) @(posedge aclk);
        chk("halted", {core_reset_n, smbus_enable, eeprom_load_req}, 3'b010);
        axr(`SRBS_OFS_STRAP, rd, rr);
        chk("strap_reg", rd, {24'h0, s});
        axw(`SRBS_OFS_SWCTL, 32'h0, rr);
        chk("release_resp", rr, `SRBS_RESP_OKAY);
      end else chk("eeprom_req", eeprom_load_req, ee);
      for (n = 0; n < 60 && core_reset_n !== 1'b1; n++) @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk("core_run", core_reset_n, 1'b1);
      chk("clocks", {ds_common_clock, us_common_clock}, {s[7], s[6]});
      chk("failover", {failover_enable, upstream_port}, {fo, port});
      axr(`SRBS_OFS_MODE, rd, rr);
      chk("mode_reg", rd, {21'h0, 3'h4, port, 1'b0, rsv, fo, ee});
      if (i < 2) begin
        // Software writes must not move the bus rate
        axw(`SRBS_OFS_SWCTL, 32'hffffffff, rr);
        for (n = 0; n < 1100 && master_smbus_tick !== 1'b1; n++) @(posedge aclk);
        @(posedge aclk);
        for (n = 1; n < 1100 && master_smbus_tick !== 1'b1; n++) @(posedge aclk);
        chk("tick_gap", n, (i == 0) ? 1000 : 250);
      end
    end
    axr(8'h40, rd, rr);
    chk("unmapped_data", rd, 32'h0);
    chk("unmapped_resp", rr, `SRBS_RESP_SLVERR);
    axw(`SRBS_OFS_STRAP, 32'h0, rr);
    axr(`SRBS_OFS_STRAP, rd, rr);
    chk("strap_ro", rd, {24'h0, s});
    axw(`SRBS_OFS_GPIO_DIR, 32'h7, rr);
    axw(`SRBS_OFS_GPIO_OUT, 32'h5, rr);
    repeat (2) @(posedge aclk);
    chk("gpio_drive", {gpio_oe, gpio_out}, 6'h3d);
    gpio_in <= 3'h2;
    repeat (3) @(posedge aclk);
    axr(`SRBS_OFS_GPIO_IN, rd, rr);
    chk("gpio_in", rd, 32'h2);
    axw(`SRBS_OFS_GPIO_ALT, 32'h1, rr);
    repeat (4) @(posedge aclk);
    chk("irq_low_pin", io_expander_irq_ten, 1'b1);
    gpio_in <= 3'h6;
    repeat (4) @(posedge aclk);
    chk("irq_high_pin", io_expander_irq_ten, 1'b0);
    tally_and_finish();
  end
endmodule
